// File: rbk_cpu_model.sv
`timescale 1ns/10ps
module rbk_cpu_model (
   input  wire logic       CLK_IN,
   output logic      [2:0] REG_NUM_IN,
   output logic            PTR_SEL_IN,
   output logic      [7:0] SFR_ADDR_IN,
   output logic            SFR_DIRECT_IN,
   output logic            SFR_WR_IN,
   output logic      [7:0] SFR_WDATA_IN,
   output logic      [1:0] SP_OP_IN
);
   initial begin
      {REG_NUM_IN, PTR_SEL_IN, SFR_ADDR_IN, SFR_DIRECT_IN} = '0;
      {SFR_WR_IN, SFR_WDATA_IN, SP_OP_IN} = '0;
   end
   // One access per cycle. Answers are read at the falling edge so that
   // combinational outputs have settled and no race with the launch edge exists.
   task automatic acc(input logic [7:0] a, input logic d, input logic w,
                      input logic [7:0] v, input logic [1:0] op);
      @(posedge CLK_IN);
      SFR_ADDR_IN <= a;
      REG_NUM_IN <= a[2:0];
      PTR_SEL_IN <= a[0];
      SFR_DIRECT_IN <= d;
      SFR_WR_IN <= w;
      SFR_WDATA_IN <= v;
      SP_OP_IN <= op;
      @(negedge CLK_IN);
   endtask
endmodule

// File: rbk_pkg.sv
package rbk_pkg;
   typedef enum logic [1:0] {
      RBK_SP_HOLD,
      RBK_SP_PUSH,
      RBK_SP_POP
   } rbk_sp_op_t;
endpackage

// File: rbk_register_bank.sv
`timescale 1ns/10ps
`include "rbk_regs.svh"
module rbk_register_bank
   import rbk_pkg::*;
#(
   parameter logic [7:0] VER0_VALUE = 8'h5A, // Arbitrary identification value.
   parameter logic [7:0] VER1_VALUE = 8'h3C, // Arbitrary identification value.
   parameter logic [7:0] VER2_VALUE = 8'h02  // Arbitrary identification value.
)(
   input  wire logic       CLK_IN,
   input  wire logic       RST_B_IN,
   input  wire logic [2:0] REG_NUM_IN,
   input  wire logic       PTR_SEL_IN,
   input  wire logic [7:0] SFR_ADDR_IN,
   input  wire logic       SFR_DIRECT_IN,
   input  wire logic       SFR_WR_IN,
   input  wire logic [7:0] SFR_WDATA_IN,
   input  wire logic [1:0] SP_OP_IN,
   output logic      [7:0] REG_ADDR_OUT,
   output logic      [7:0] PTR_ADDR_OUT,
   output logic      [7:0] SP_OUT,
   output logic      [7:0] STACK_ADDR_OUT,
   output logic      [1:0] BANK_OUT,
   output logic            MAP_SEL_OUT,
   output logic      [7:0] SFR_RDATA_OUT,
   output logic            SFR_HIT_OUT,
   output logic            SFR_BIT_ADDR_OUT,
   output logic            IRAM_UPPER_OUT
);

   // ----------------------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------------------
   // Reset takes hold at once but leaves two edges later, so no register
   // comes out of reset on an edge that could see a metastable level.
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Bank base times eight plus register number; bank space is 32 bytes.
   function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] num);
      bank_addr = {3'h0, bank, num};
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] msk);
      merge = (old & ~msk) | (nw & msk);
   endfunction

   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
      addr_is = (addr == target);
   endfunction

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] sp_q;
   logic [7:0] sp_d;
   logic [7:0] ctl_q;
   logic [7:0] ctl_d;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic [7:0] pwr_ext_q;
   logic [7:0] pwr_ext_d;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic       sfr_space;
   logic       map_on;
   logic       sel_ctl;
   logic       sel_sp;
   logic       sel_status;
   logic       sel_ver0;
   logic       sel_ver1;
   logic       sel_ver2;
   logic       sel_pwr;
   logic       wr_ctl;
   logic       wr_sp;
   logic       wr_status;
   logic       wr_pwr;
   rbk_sp_op_t sp_op;

   assign sp_op      = rbk_sp_op_t'(SP_OP_IN);
   // Upper RAM shares these addresses; only direct accesses see the registers.
   assign sfr_space  = SFR_DIRECT_IN && (SFR_ADDR_IN >= `RBK_SFR_BASE);
   assign map_on     = ctl_q[`RBK_MAP_BIT];
   // System control answers in both areas, otherwise software could never
   // clear the map bit again once it is set.
   assign sel_ctl    = sfr_space && addr_is(SFR_ADDR_IN, `RBK_ADDR_SYS_CTL);
   assign sel_sp     = sfr_space && !map_on && addr_is(SFR_ADDR_IN, `RBK_ADDR_SP);
   assign sel_status = sfr_space && !map_on && addr_is(SFR_ADDR_IN, `RBK_ADDR_STATUS);
   // Version registers answer only in the standard area.
   assign sel_ver0   = sfr_space && !map_on && addr_is(SFR_ADDR_IN, `RBK_ADDR_VER0);
   assign sel_ver1   = sfr_space && !map_on && addr_is(SFR_ADDR_IN, `RBK_ADDR_VER1);
   assign sel_ver2   = sfr_space && !map_on && addr_is(SFR_ADDR_IN, `RBK_ADDR_VER2);
   assign sel_pwr    = sfr_space && map_on && addr_is(SFR_ADDR_IN, `RBK_ADDR_PWR_EXT);
   assign wr_ctl     = sel_ctl && SFR_WR_IN;
   assign wr_sp      = sel_sp && SFR_WR_IN;
   assign wr_status  = sel_status && SFR_WR_IN;
   assign wr_pwr     = sel_pwr && SFR_WR_IN;

   // ----------------------------------------------------------------
   // Stack pointer
   // ----------------------------------------------------------------
   // A push or pop in the same cycle as a software write wins and the write
   // is lost; the instruction engine never issues both at once.
   always_comb begin
      sp_d = sp_q;
      case (sp_op)
         RBK_SP_PUSH: begin
            sp_d = sp_q + 8'h01;
         end
         RBK_SP_POP: begin
            sp_d = sp_q - 8'h01;
         end
         RBK_SP_HOLD: begin
            if (wr_sp) begin
               sp_d = SFR_WDATA_IN;
            end
         end
         default: begin
            sp_d = sp_q;
         end
      endcase
   end

   always_ff @(posedge CLK_IN or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         sp_q <= `RBK_SP_RESET;
      end else begin
         sp_q <= sp_d;
      end
   end

   // ----------------------------------------------------------------
   // System control
   // ----------------------------------------------------------------
   // Bits 5 and 4 are fixed; the map bit changes only on a software write.
   always_comb begin
      ctl_d = ctl_q;
      if (wr_ctl) begin
         ctl_d = merge(ctl_q, SFR_WDATA_IN, `RBK_SYS_CTL_WMASK);
      end else begin
         ctl_d = ctl_q;
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         ctl_q <= `RBK_SYS_CTL_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // ----------------------------------------------------------------
   // Program status word
   // ----------------------------------------------------------------
   // The whole byte is kept here; only the two bank select bits are used,
   // the flags belong to the arithmetic logic outside this block.
   always_comb begin
      status_d = status_q;
      if (wr_status) begin
         status_d = SFR_WDATA_IN;
      end else begin
         status_d = status_q;
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         status_q <= `RBK_STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // ----------------------------------------------------------------
   // Extended power control
   // ----------------------------------------------------------------
   // Reachable only with the map bit set; with it clear the same address
   // belongs to a block outside this one.
   always_comb begin
      pwr_ext_d = pwr_ext_q;
      if (wr_pwr) begin
         pwr_ext_d = merge(pwr_ext_q, SFR_WDATA_IN, `RBK_PWR_EXT_WMASK);
      end else begin
         pwr_ext_d = pwr_ext_q;
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         pwr_ext_q <= `RBK_PWR_EXT_RESET;
      end else begin
         pwr_ext_q <= pwr_ext_d;
      end
   end

   // ----------------------------------------------------------------
   // Operand addressing
   // ----------------------------------------------------------------
   logic [1:0] bank;
   logic [7:0] reg_addr;
   logic [7:0] ptr_addr;
   logic [7:0] stack_addr;

   assign bank = {status_q[`RBK_BANK_HI_BIT], status_q[`RBK_BANK_LO_BIT]};

   // Bank and register number together land in the low 32 bytes of RAM.
   always_comb begin
      reg_addr = bank_addr(bank, REG_NUM_IN);
      ptr_addr = bank_addr(bank, {2'b00, PTR_SEL_IN});
   end

   // Push writes at the incremented pointer, pop reads at the current one.
   always_comb begin
      stack_addr = sp_q;
      case (sp_op)
         RBK_SP_PUSH: begin
            stack_addr = sp_q + 8'h01;
         end
         RBK_SP_POP: begin
            stack_addr = sp_q;
         end
         default: begin
            stack_addr = sp_q;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [7:0] std_rdata;
   logic       std_hit;
   logic [7:0] map_rdata;
   logic       map_hit;
   logic [7:0] rdata;
   logic       hit;

   // Version registers have no state, so writes to them fall on nothing.
   always_comb begin
      std_rdata = 8'h00;
      std_hit   = 1'b1;
      case (1'b1)
         sel_sp: begin
            std_rdata = sp_q;
         end
         sel_status: begin
            std_rdata = status_q;
         end
         sel_ver0: begin
            std_rdata = VER0_VALUE;
         end
         sel_ver1: begin
            std_rdata = VER1_VALUE;
         end
         sel_ver2: begin
            std_rdata = VER2_VALUE;
         end
         default: begin
            std_rdata = 8'h00;
            std_hit   = 1'b0;
         end
      endcase
   end

   always_comb begin
      map_rdata = 8'h00;
      map_hit   = 1'b0;
      if (sel_pwr) begin
         map_rdata = pwr_ext_q;
         map_hit   = 1'b1;
      end
   end

   // At most one select is high; the order only fixes a priority for safety.
   always_comb begin
      rdata = 8'h00;
      hit   = 1'b0;
      if (sel_ctl) begin
         rdata = ctl_q;
         hit   = 1'b1;
      end else if (map_hit) begin
         rdata = map_rdata;
         hit   = 1'b1;
      end else if (std_hit) begin
         rdata = std_rdata;
         hit   = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Area flags
   // ----------------------------------------------------------------
   logic       bit_addr;
   logic       upper_ram;

   // Bit addressing follows sfr_space and the low address bits only, whether or not a
   // register of this block answers at that address.
   always_comb begin
      bit_addr  = 1'b0;
      upper_ram = 1'b0;
      if (sfr_space) begin
         bit_addr = (SFR_ADDR_IN[2:0] == 3'h0);
      end
      if (!SFR_DIRECT_IN && (SFR_ADDR_IN >= `RBK_SFR_BASE)) begin
         upper_ram = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign REG_ADDR_OUT     = reg_addr;
   assign PTR_ADDR_OUT     = ptr_addr;
   assign SP_OUT           = sp_q;
   assign STACK_ADDR_OUT   = stack_addr;
   assign BANK_OUT         = bank;
   assign MAP_SEL_OUT      = map_on;
   assign SFR_RDATA_OUT    = rdata;
   assign SFR_HIT_OUT      = hit;
   assign SFR_BIT_ADDR_OUT = bit_addr;
   assign IRAM_UPPER_OUT   = upper_ram;

endmodule

// File: rbk_register_bank_bench.sv
`timescale 1ns/10ps
module rbk_register_bank_bench;
   logic       CLK_IN = 1'b0, RST_B_IN = 1'b0, PTR_SEL_IN, SFR_DIRECT_IN, SFR_WR_IN;
   logic       MAP_SEL_OUT, SFR_HIT_OUT, SFR_BIT_ADDR_OUT, IRAM_UPPER_OUT;
   logic [1:0] SP_OP_IN, BANK_OUT;
   logic [2:0] REG_NUM_IN;
   logic [7:0] SFR_ADDR_IN, SFR_WDATA_IN, REG_ADDR_OUT, PTR_ADDR_OUT, SP_OUT, STACK_ADDR_OUT, SFR_RDATA_OUT;
   int         failures = 0, comparisons = 0;
   always #25 CLK_IN = ~CLK_IN;
   rbk_cpu_model u_rbk_cpu_model (.*);
   rbk_register_bank #(.VER2_VALUE(8'h33)) u_rbk_register_bank (.*);
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge CLK_IN);
      RST_B_IN <= 1'b1;
      repeat (3) u_rbk_cpu_model.acc(8'h00, 0, 0, 8'h00, 2'h0);
      u_rbk_cpu_model.acc(8'hB1, 1, 0, 8'h00, 2'h0);
      chk("sp", SP_OUT, 8'h07);
      chk("sysctl", 8'(SFR_RDATA_OUT[5:4]), 8'h02);
      $display("test reset done");
      for (int b = 0; b < 4; b++) begin
         u_rbk_cpu_model.acc(8'hD0, 1, 1, 8'(b << 3), 2'h0);
         u_rbk_cpu_model.acc(8'h07, 1, 0, 8'h00, 2'h0);
         chk("bank", 8'(BANK_OUT), 8'(b));
         chk("reg", REG_ADDR_OUT, 8'(b * 8 + 7));
         chk("ptr", PTR_ADDR_OUT, 8'(b * 8 + 1));
      end
      $display("test banks done");
      u_rbk_cpu_model.acc(8'h00, 0, 0, 8'h00, 2'h1);
      chk("push addr", STACK_ADDR_OUT, 8'h08);
      u_rbk_cpu_model.acc(8'h00, 0, 0, 8'h00, 2'h2);
      chk("sp push", SP_OUT, 8'h08);
      chk("pop addr", STACK_ADDR_OUT, 8'h08);
      u_rbk_cpu_model.acc(8'h00, 0, 0, 8'h00, 2'h0);
      chk("sp pop", SP_OUT, 8'h07);
      $display("test stack done");
      u_rbk_cpu_model.acc(8'hB1, 1, 1, 8'h01, 2'h0);
      u_rbk_cpu_model.acc(8'h88, 1, 1, 8'hFF, 2'h0);
      chk("map", 8'(MAP_SEL_OUT), 8'h01);
      chk("hit", 8'(SFR_HIT_OUT), 8'h01);
      chk("bitaddr", 8'(SFR_BIT_ADDR_OUT), 8'h01);
      u_rbk_cpu_model.acc(8'h88, 1, 0, 8'h00, 2'h0);
      chk("pwr ext", SFR_RDATA_OUT, 8'h90);
      chk("map held", 8'(MAP_SEL_OUT), 8'h01);
      u_rbk_cpu_model.acc(8'hD0, 1, 1, 8'h00, 2'h0);
      u_rbk_cpu_model.acc(8'h88, 0, 0, 8'h00, 2'h0);
      chk("bank kept", 8'(BANK_OUT), 8'h03);
      chk("indirect hit", 8'(SFR_HIT_OUT), 8'h00);
      chk("upper", 8'(IRAM_UPPER_OUT), 8'h01);
      u_rbk_cpu_model.acc(8'hB1, 1, 1, 8'h00, 2'h0);
      u_rbk_cpu_model.acc(8'h88, 1, 0, 8'h00, 2'h0);
      chk("std hit", 8'(SFR_HIT_OUT), 8'h00);
      u_rbk_cpu_model.acc(8'h89, 1, 0, 8'h00, 2'h0);
      chk("byte only", 8'(SFR_BIT_ADDR_OUT), 8'h00);
      u_rbk_cpu_model.acc(8'hFE, 1, 1, 8'hFF, 2'h0);
      u_rbk_cpu_model.acc(8'hFE, 1, 0, 8'h00, 2'h0);
      chk("version", SFR_RDATA_OUT, 8'h33);
      $display("test map done");
      test_done();
   end
endmodule
bind rbk_register_bank rbk_register_bank_monitor u_rbk_register_bank_monitor (.*);

// File: rbk_register_bank_monitor.sv
`timescale 1ns/10ps
module rbk_register_bank_monitor (
   input wire logic       CLK_IN,
   input wire logic       RST_B_IN,
   input wire logic [2:0] REG_NUM_IN,
   input wire logic       PTR_SEL_IN,
   input wire logic [7:0] SFR_ADDR_IN,
   input wire logic       SFR_DIRECT_IN,
   input wire logic       SFR_WR_IN,
   input wire logic [7:0] SFR_WDATA_IN,
   input wire logic [1:0] SP_OP_IN,
   input wire logic [7:0] REG_ADDR_OUT,
   input wire logic [7:0] PTR_ADDR_OUT,
   input wire logic [7:0] SP_OUT,
   input wire logic [7:0] STACK_ADDR_OUT,
   input wire logic [1:0] BANK_OUT,
   input wire logic       MAP_SEL_OUT,
   input wire logic       SFR_BIT_ADDR_OUT,
   input wire logic       IRAM_UPPER_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   sequence ctl_write;
      SFR_WR_IN && SFR_DIRECT_IN && SFR_ADDR_IN == 8'hB1;
   endsequence
   a_reg_addr_map: assert property (REG_ADDR_OUT == {3'h0, BANK_OUT, REG_NUM_IN})
      else $error("Register operand address wrong");
   a_ptr_addr_map: assert property (PTR_ADDR_OUT == {3'h0, BANK_OUT, 2'h0, PTR_SEL_IN})
      else $error("Pointer register address wrong");
   a_push_sp_inc: assert property (SP_OP_IN == 2'h1 |=> SP_OUT == $past(SP_OUT) + 8'h01)
      else $error("Stack pointer not raised on push");
   a_pop_sp_dec: assert property (SP_OP_IN == 2'h2 |=> SP_OUT == $past(SP_OUT) - 8'h01)
      else $error("Stack pointer not lowered on pop");
   a_push_pre_inc: assert property (SP_OP_IN == 2'h1 |-> STACK_ADDR_OUT == SP_OUT + 8'h01)
      else $error("Push store address wrong");
   a_map_write: assert property (ctl_write |=> MAP_SEL_OUT == $past(SFR_WDATA_IN[0]))
      else $error("Map select not written");
   a_map_hold: assert property (not ctl_write |=> $stable(MAP_SEL_OUT))
      else $error("Map select changed without a write");
   a_bit_addr: assert property (SFR_BIT_ADDR_OUT == (SFR_DIRECT_IN && SFR_ADDR_IN[7] && SFR_ADDR_IN[2:0] == 3'h0))
      else $error("Bit addressable flag wrong");
   a_upper_ram: assert property (IRAM_UPPER_OUT == (!SFR_DIRECT_IN && SFR_ADDR_IN[7]))
      else $error("Upper RAM flag wrong");
endmodule

// File: rbk_regs.svh
`ifndef RBK_REGS_SVH
`define RBK_REGS_SVH
`define RBK_ADDR_SP        8'h81
`define RBK_ADDR_SYS_CTL   8'hB1
`define RBK_ADDR_STATUS    8'hD0
`define RBK_ADDR_VER0      8'hFC
`define RBK_ADDR_VER1      8'hFD
`define RBK_ADDR_VER2      8'hFE
`define RBK_ADDR_PWR_EXT   8'h88
`define RBK_SP_RESET       8'h07
`define RBK_SYS_CTL_RESET  8'h20
`define RBK_SYS_CTL_WMASK  8'hCF
`define RBK_STATUS_RESET   8'h00
`define RBK_PWR_EXT_RESET  8'h00
`define RBK_PWR_EXT_WMASK  8'h90
`define RBK_MAP_BIT        0
`define RBK_BANK_LO_BIT    3
`define RBK_BANK_HI_BIT    4
`define RBK_SFR_BASE       8'h80
`define RBK_BANK_SPAN      8'h20
`endif
